// File: hw/dpwr_defs.svh
// Purpose: constants of the wiper register core
// Assumes: 20 MHz core clock
// Notes: included by the core and the tap decoder
//
// Functional notes
// - Write-protect low blocks every update of the four stored settings.
// - Write-protect never blocks host writes to the wiper position counter.
// - Serial input is sampled on the rising serial clock edge.
// - Serial output is high impedance unless it drives read data.
// - Sixty-three series segments, one tap at every counter position.
// - Exactly one tap switch is on at any moment.
// - Six counter bits decode to one of sixty-four tap enables.
// - Wiper position is a 6-bit counter with serial and parallel load.
// - Write-wiper command loads the counter from the shifted-in byte.
// - Transfer command parallel-loads the counter from the chosen stored setting.
// - Step command moves the counter one position per serial clock in the requested direction, holding at either end.
// - After power-up the counter is loaded from stored setting zero.
// - Counter is volatile; after power-up it holds stored setting zero.
// - Four 6-bit stored settings the host reads and writes directly.
// - Transfers run both ways between stored settings and the counter.
// - A stored-setting update completes within at most 10 ms.
// - Registers read as a byte, top two bits zero, value below.
// - Stored save starts only on select rising after a complete write.
// - Busy flag stays set during the save and reads via status command.
// - Read data shifts out on the falling serial clock edge.
// - All traffic is ignored until select has fallen after power-up.
`ifndef DPWR_DEFS_SVH
`define DPWR_DEFS_SVH

`define DPWR_CLK_HZ       20000000
`define DPWR_T_NVWR_MS    10
`define DPWR_NVWR_CYCLES  (`DPWR_T_NVWR_MS * (`DPWR_CLK_HZ / 1000))
// Device type code in the select byte is arbitrary
`define DPWR_ID_TYPE      7'h35
`define DPWR_NV_RESET     6'h00
`define DPWR_POS_MAX      6'h3F
`define DPWR_POS_MIN      6'h00
`define DPWR_NUM_TAPS     64
`define DPWR_OP_MSB       7
`define DPWR_OP_LSB       4
`define DPWR_PTR_MSB      3
`define DPWR_PTR_LSB      2

`endif

// File: hw/dpwr_pkg.sv
// Purpose: shared types of the wiper register core
// Assumes: nothing
// Notes: state and command codes
package dpwr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ID     = 3'h1,
        ST_INS    = 3'h2,
        ST_WDATA  = 3'h3,
        ST_RDATA  = 3'h4,
        ST_STEP   = 3'h5,
        ST_SKIP   = 3'h6
    } dpwr_state_e;

    typedef enum logic [3:0] {
        OP_RD_WIPER = 4'h9,
        OP_WR_WIPER = 4'hA,
        OP_RD_STORE = 4'hB,
        OP_WR_STORE = 4'hC,
        OP_XFR_LOAD = 4'hD,
        OP_XFR_SAVE = 4'hE,
        OP_STEP     = 4'h2,
        OP_STATUS   = 4'h5
    } dpwr_op_e;

    typedef logic [5:0] dpwr_pos_t;

endpackage

// File: hw/dpwr_tap_decode.sv
// Purpose: one-hot tap switch decoder
// Assumes: position from core clock domain
// Notes: registered, so no decode glitch reaches the switches
`timescale 1ns/10ps
`include "dpwr_defs.svh"
module dpwr_tap_decode (
    // Clock and reset
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,
    // Position in
    input  wire dpwr_pkg::dpwr_pos_t         i_pos,
    // Tap enables out
    output logic [`DPWR_NUM_TAPS-1:0]        o_tap_en
);

    genvar g;
    generate
        for (g = 0; g < `DPWR_NUM_TAPS; g = g + 1) begin : g_tap
            always_ff @(posedge i_mclk) begin
                if (!i_rst_n) begin
                    o_tap_en[g] <= (g == 0);
                end else begin
                    o_tap_en[g] <= (i_pos == 6'(g));
                end
            end
        end
    endgenerate

endmodule

// File: hw/dpwr_core.sv
// Purpose: serial register core of a 64-tap digital potentiometer
// Assumes: all pins asynchronous to i_mclk; serial clock far below i_mclk
// Notes: stored settings are modelled as flops cleared by reset
`timescale 1ns/10ps
`include "dpwr_defs.svh"
module dpwr_core #(
    parameter int NVWR_CYCLES = `DPWR_NVWR_CYCLES
) (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    // Serial host pins
    input  wire logic                   i_sck,
    input  wire logic                   i_si,
    input  wire logic                   i_cs_n,
    input  wire logic                   i_hold_n,
    input  wire logic                   i_wp_n,
    input  wire logic                   i_a0,
    output logic                        o_so,
    output logic                        o_so_oe,
    // Potentiometer switches
    output logic [`DPWR_NUM_TAPS-1:0]   o_tap_en,
    // Status
    output logic                        o_nv_busy
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [1:0] sck_sync;
    logic [1:0] si_sync;
    logic [1:0] cs_sync;
    logic [1:0] hold_sync;
    logic [1:0] wp_sync;
    logic [1:0] a0_sync;
    logic       sck_d;
    logic       cs_d;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sck_sync  <= 2'h0;
            si_sync   <= 2'h0;
            cs_sync   <= 2'h3;
            hold_sync <= 2'h3;
            wp_sync   <= 2'h3;
            a0_sync   <= 2'h0;
            sck_d     <= 1'b0;
            cs_d      <= 1'b1;
        end else begin
            sck_sync  <= {sck_sync[0], i_sck};
            si_sync   <= {si_sync[0], i_si};
            cs_sync   <= {cs_sync[0], i_cs_n};
            hold_sync <= {hold_sync[0], i_hold_n};
            wp_sync   <= {wp_sync[0], i_wp_n};
            a0_sync   <= {a0_sync[0], i_a0};
            sck_d     <= sck_sync[1];
            cs_d      <= cs_sync[1];
        end
    end

    logic sck_s;
    logic si_s;
    logic cs_n_s;
    logic hold_n_s;
    logic wp_n_s;
    logic a0_s;

    assign sck_s    = sck_sync[1];
    assign si_s     = si_sync[1];
    assign cs_n_s   = cs_sync[1];
    assign hold_n_s = hold_sync[1];
    assign wp_n_s   = wp_sync[1];
    assign a0_s     = a0_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Edge events

    logic cs_fall;
    logic cs_rise;
    logic active;
    logic sck_rise;
    logic sck_fall;

    logic       cs_armed;
    logic [1:0] cs_warm;

    // Reset values of the select synchroniser are no real sample of the pin
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cs_warm  <= 2'h0;
            cs_armed <= 1'b0;
        end else begin
            cs_warm  <= {cs_warm[0], 1'b1};
            cs_armed <= cs_armed | (cs_warm[1] & cs_n_s);
        end
    end

    // Select held low through reset must rise once before a frame counts
    assign cs_fall  = cs_armed & cs_d & ~cs_n_s;
    assign cs_rise  = ~cs_d & cs_n_s;

    dpwr_pkg::dpwr_state_e state;
    dpwr_pkg::dpwr_state_e next_state;

    // Pause freezes the sequence without losing it
    assign active   = ~cs_n_s & hold_n_s & (state != dpwr_pkg::ST_IDLE);
    assign sck_rise = active & sck_s & ~sck_d;
    assign sck_fall = active & ~sck_s & sck_d;

    ////////////////////////////////////////////////////////////////////////
    // Byte assembly

    logic [2:0]          bit_cnt;
    logic [6:0]          shreg;
    logic [7:0]          byte_in;
    logic                byte_done;
    dpwr_pkg::dpwr_op_e  op;
    logic [1:0]          ptr;
    logic [3:0]          op_raw;

    assign byte_in   = {shreg, si_s};
    assign byte_done = sck_rise & (bit_cnt == 3'h7);
    assign op_raw    = byte_in[`DPWR_OP_MSB:`DPWR_OP_LSB];
    assign op        = dpwr_pkg::dpwr_op_e'(op_raw);
    assign ptr       = byte_in[`DPWR_PTR_MSB:`DPWR_PTR_LSB];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            bit_cnt <= 3'h0;
            shreg   <= 7'h00;
        end else if (cs_fall) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg   <= byte_in[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer

    logic               busy;
    logic               id_match;
    logic               refuse;
    dpwr_pkg::dpwr_op_e op_q;
    logic [1:0]         ptr_q;

    assign id_match = (byte_in == {`DPWR_ID_TYPE, a0_s});
    // While saving, only the status read is served
    assign refuse   = busy & (op != dpwr_pkg::OP_STATUS);

    always_comb begin
        next_state = state;
        case (state)
            dpwr_pkg::ST_IDLE: begin
                next_state = dpwr_pkg::ST_IDLE;
            end
            dpwr_pkg::ST_ID: begin
                if (byte_done) begin
                    next_state = id_match ? dpwr_pkg::ST_INS : dpwr_pkg::ST_SKIP;
                end
            end
            dpwr_pkg::ST_INS: begin
                if (byte_done) begin
                    next_state = dpwr_pkg::ST_SKIP;
                    if (!refuse) begin
                        case (op)
                            dpwr_pkg::OP_RD_WIPER: next_state = dpwr_pkg::ST_RDATA;
                            dpwr_pkg::OP_RD_STORE: next_state = dpwr_pkg::ST_RDATA;
                            dpwr_pkg::OP_STATUS:   next_state = dpwr_pkg::ST_RDATA;
                            dpwr_pkg::OP_WR_WIPER: next_state = dpwr_pkg::ST_WDATA;
                            dpwr_pkg::OP_WR_STORE: next_state = dpwr_pkg::ST_WDATA;
                            dpwr_pkg::OP_STEP:     next_state = dpwr_pkg::ST_STEP;
                            default:               next_state = dpwr_pkg::ST_SKIP;
                        endcase
                    end
                end
            end
            dpwr_pkg::ST_WDATA: begin
                if (byte_done) begin
                    next_state = dpwr_pkg::ST_SKIP;
                end
            end
            dpwr_pkg::ST_RDATA: begin
                if (byte_done) begin
                    next_state = dpwr_pkg::ST_SKIP;
                end
            end
            dpwr_pkg::ST_STEP: begin
                next_state = dpwr_pkg::ST_STEP;
            end
            dpwr_pkg::ST_SKIP: begin
                next_state = dpwr_pkg::ST_SKIP;
            end
            default: begin
                next_state = dpwr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state <= dpwr_pkg::ST_IDLE;
        end else if (cs_n_s) begin
            state <= dpwr_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state <= dpwr_pkg::ST_ID;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            op_q  <= dpwr_pkg::OP_STATUS;
            ptr_q <= 2'h0;
        end else if (byte_done && state == dpwr_pkg::ST_INS) begin
            op_q  <= op;
            ptr_q <= ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored settings and save cycle

    logic [5:0]  store [4];
    logic        save_pend;
    logic [1:0]  save_ptr;
    logic [5:0]  save_val;
    logic        wp_seen;
    logic        save_go;
    logic [31:0] save_cnt;
    logic        recall;
    dpwr_pkg::dpwr_pos_t wiper;

    // Protect low at any point of the frame voids the save
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wp_seen <= 1'b0;
        end else if (cs_fall) begin
            wp_seen <= ~wp_n_s;
        end else if (!cs_n_s && !wp_n_s) begin
            wp_seen <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            save_pend <= 1'b0;
            save_ptr  <= 2'h0;
            save_val  <= `DPWR_NV_RESET;
        end else if (cs_fall || cs_rise) begin
            save_pend <= 1'b0;
        end else if (byte_done && state == dpwr_pkg::ST_INS && !refuse
                     && op == dpwr_pkg::OP_XFR_SAVE) begin
            save_pend <= 1'b1;
            save_ptr  <= ptr;
            save_val  <= wiper;
        end else if (byte_done && state == dpwr_pkg::ST_WDATA
                     && op_q == dpwr_pkg::OP_WR_STORE) begin
            save_pend <= 1'b1;
            save_ptr  <= ptr_q;
            save_val  <= byte_in[5:0];
        end else if (sck_rise && state == dpwr_pkg::ST_SKIP) begin
            save_pend <= 1'b0;
        end
    end

    assign save_go = cs_rise & save_pend & ~wp_seen & wp_n_s & ~busy;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 4; i++) begin
                store[i] <= `DPWR_NV_RESET;
            end
        end else if (save_go) begin
            store[save_ptr] <= save_val;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            busy     <= 1'b0;
            save_cnt <= 32'h0;
        end else if (save_go) begin
            busy     <= 1'b1;
            save_cnt <= 32'(NVWR_CYCLES - 1);
        end else if (busy) begin
            if (save_cnt == 32'h0) begin
                busy <= 1'b0;
            end else begin
                save_cnt <= save_cnt - 32'h1;
            end
        end
    end

    assign o_nv_busy = busy;

    ////////////////////////////////////////////////////////////////////////
    // Wiper position counter

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            recall <= 1'b1;
        end else begin
            recall <= 1'b0;
        end
    end

    // Write protect is not consulted here
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wiper <= `DPWR_POS_MIN;
        end else if (recall) begin
            wiper <= store[0];
        end else if (byte_done && state == dpwr_pkg::ST_INS && !refuse
                     && op == dpwr_pkg::OP_XFR_LOAD) begin
            wiper <= store[ptr];
        end else if (byte_done && state == dpwr_pkg::ST_WDATA
                     && op_q == dpwr_pkg::OP_WR_WIPER) begin
            wiper <= byte_in[5:0];
        end else if (sck_rise && state == dpwr_pkg::ST_STEP) begin
            if (si_s && wiper != `DPWR_POS_MAX) begin
                wiper <= wiper + 6'h01;
            end else if (!si_s && wiper != `DPWR_POS_MIN) begin
                wiper <= wiper - 6'h01;
            end
        end
    end

    dpwr_tap_decode u_tap (
        .i_mclk   (i_mclk),
        .i_rst_n  (i_rst_n),
        .i_pos    (wiper),
        .o_tap_en (o_tap_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data path

    logic [7:0] rd_shift;
    logic [7:0] rd_load;

    always_comb begin
        case (op)
            dpwr_pkg::OP_RD_WIPER: rd_load = {2'h0, wiper};
            dpwr_pkg::OP_RD_STORE: rd_load = {2'h0, store[ptr]};
            dpwr_pkg::OP_STATUS:   rd_load = {7'h00, busy};
            default:               rd_load = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rd_shift <= 8'h00;
            o_so     <= 1'b0;
        end else if (byte_done && state == dpwr_pkg::ST_INS) begin
            rd_shift <= rd_load;
        end else if (sck_fall && state == dpwr_pkg::ST_RDATA) begin
            o_so     <= rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end

    // Released outside the read byte so the pin may share the input wire
    assign o_so_oe = (state == dpwr_pkg::ST_RDATA) & ~cs_n_s & hold_n_s;

endmodule

// File: testbench/dpwr_core_assertions.sv
// Purpose: port-level checks of the wiper register core
// Assumes: serial clock far slower than i_mclk
// Notes: bound to dpwr_core below
`timescale 1ns/10ps
`include "dpwr_defs.svh"
module dpwr_chk #(
    parameter int NVWR_CYCLES = `DPWR_NVWR_CYCLES
) (
    input wire logic                      i_mclk,
    input wire logic                      i_rst_n,
    input wire logic                      i_sck,
    input wire logic                      i_si,
    input wire logic                      i_cs_n,
    input wire logic                      i_hold_n,
    input wire logic                      i_wp_n,
    input wire logic                      i_a0,
    input wire logic                      o_so,
    input wire logic                      o_so_oe,
    input wire logic [`DPWR_NUM_TAPS-1:0] o_tap_en,
    input wire logic                      o_nv_busy
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    int busy_cnt;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !o_nv_busy)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_cs_idle;
        i_cs_n [*5];
    endsequence
    sequence s_save_start;
        $rose(o_nv_busy);
    endsequence

    a_tap_onehot: assert property ($onehot(o_tap_en))
        else $error("tap enables not one-hot");
    a_so_released: assert property (s_cs_idle |-> !o_so_oe)
        else $error("serial out driven while deselected");
    a_wp_blocks: assert property (s_save_start |-> i_wp_n && $past(i_wp_n, 8))
        else $error("save started under write protect");
    a_save_on_cs: assert property (s_save_start |-> $past(i_cs_n, 2) && i_cs_n)
        else $error("save started before select rose");
    a_busy_exact: assert property ($fell(o_nv_busy) |-> busy_cnt == NVWR_CYCLES)
        else $error("busy length wrong");
    a_busy_cap: assert property (busy_cnt <= NVWR_CYCLES)
        else $error("save runs too long");
    a_reset_tap: assert property ($rose(i_rst_n) |-> o_tap_en == 64'h1)
        else $error("wiper not at stored setting zero after reset");
    a_tap_idle: assert property (i_cs_n [*8] |-> $stable(o_tap_en))
        else $error("wiper moved outside a frame");
    a_so_fall: assert property ($changed(o_so) && o_so_oe
        |-> !$past(i_sck, 1) && !$past(i_sck, 2))
        else $error("serial out changed off the falling edge");
endmodule

bind dpwr_core dpwr_chk #(.NVWR_CYCLES(NVWR_CYCLES)) u_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_si(i_si),
    .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .i_a0(i_a0),
    .o_so(o_so), .o_so_oe(o_so_oe), .o_tap_en(o_tap_en), .o_nv_busy(o_nv_busy)
);

// File: testbench/dpwr_host.sv
// Purpose: serial host model, mode 0
// Assumes: serial clock period of eight core clocks
// Notes: clock stands low between frames
`timescale 1ns/10ps
module dpwr_host (
    // Clock
    input  wire logic i_mclk,
    // Serial pins
    input  wire logic i_so,
    output logic      o_sck,
    output logic      o_si,
    output logic      o_cs_n
);
    initial begin
        o_sck = 1'b0;
        o_si = 1'b0;
        o_cs_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // Bits leave MSB first from d[31]; last eight received land in rx
    task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rx);
        o_cs_n <= 1'b0;
        tick(8);
        for (int i = 0; i < n; i++) begin
            o_si <= d[31-i];
            tick(4);
            o_sck <= 1'b1;
            rx = {rx[6:0], i_so};
            tick(4);
            o_sck <= 1'b0;
        end
        tick(8);
        o_cs_n <= 1'b1;
        // Released line shows no stale bit
        o_si <= ~o_si;
        tick(8);
    endtask
endmodule

// File: testbench/dpwr_core_bench.sv
// Purpose: self-checking bench of the wiper register core
// Assumes: save shortened to 400 cycles
// Notes: status is polled inside the save window
`timescale 1ns/10ps
`include "dpwr_defs.svh"
module dpwr_core_bench;
    logic                      mclk;
    logic                      rst_n;
    logic                      hold_n;
    logic                      wp_n;
    logic                      a0;
    logic                      sck;
    logic                      si;
    logic                      cs_n;
    logic                      so;
    logic                      so_oe;
    logic [`DPWR_NUM_TAPS-1:0] tap_en;
    logic                      busy;
    logic [7:0]                rx;
    int                        bad_count;
    int                        checks_done;

    localparam logic [7:0]     ID_BYTE = {`DPWR_ID_TYPE, 1'b0};

    dpwr_core #(.NVWR_CYCLES(400)) dut (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_sck(sck), .i_si(si), .i_cs_n(cs_n),
        .i_hold_n(hold_n), .i_wp_n(wp_n), .i_a0(a0), .o_so(so), .o_so_oe(so_oe),
        .o_tap_en(tap_en), .o_nv_busy(busy)
    );
    // Released pin reads as the inverse of its last bit
    dpwr_host host (.i_mclk(mclk), .i_so(so_oe ? so : ~so), .o_sck(sck), .o_si(si),
        .o_cs_n(cs_n));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xf(input logic [31:0] d, input int n);
        host.frame(d, n, rx);
    endtask

    task automatic wr(input logic [7:0] ins, input logic [7:0] dat);
        xf({ID_BYTE, ins, dat, 8'h00}, 24);
    endtask

    task automatic rd(input logic [7:0] ins);
        xf({ID_BYTE, ins, 16'h0000}, 24);
    endtask

    // Bounded wait for the busy level
    task automatic waitb(input logic lv);
        int k;
        k = 0;
        while (busy !== lv && k < 1000) begin
            @(posedge mclk);
            k++;
        end
        if (busy !== lv) begin
            bad_count++;
            summarize();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        a0 = 1'b0;
        bad_count = 0;
        checks_done = 0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("tap_reset", tap_en, 64'h1);
        chk("oe_idle", so_oe, 1'b0);
        // Protected: wiper writes go, stored writes do not
        wp_n <= 1'b0;
        wr(8'hA0, 8'h2A);
        chk("tap_write", tap_en, 64'h1 << 42);
        rd(8'h90);
        chk("rd_wiper", rx, 8'h2A);
        wr(8'hC8, 8'h33);
        chk("busy_prot", busy, 1'b0);
        wp_n <= 1'b1;
        rd(8'hB8);
        chk("rd_prot", rx, 8'h00);
        // Save, status polled during and after it
        wr(8'hC4, 8'h15);
        rd(8'h51);
        chk("status_busy", rx, 8'h01);
        waitb(1'b0);
        rd(8'h51);
        chk("status_idle", rx, 8'h00);
        rd(8'hB4);
        chk("rd_store1", rx, 8'h15);
        // Short and overlong writes are dropped; transfers load and save
        xf({ID_BYTE, 8'hC8, 16'h0000}, 16);
        chk("busy_short", busy, 1'b0);
        xf({ID_BYTE, 8'hC8, 8'h11, 8'h80}, 25);
        chk("busy_long", busy, 1'b0);
        xf({ID_BYTE, 8'hD4, 16'h0000}, 16);
        chk("tap_load", tap_en, 64'h1 << 21);
        wr(8'hA0, 8'h3E);
        xf({ID_BYTE, 8'hEC, 16'h0000}, 16);
        waitb(1'b1);
        waitb(1'b0);
        rd(8'hBC);
        chk("rd_store3", rx, 8'h3E);
        // Stepping holds at both ends; wrap would land elsewhere
        xf({ID_BYTE, 8'h20, 4'hE, 12'h000}, 20);
        rd(8'h90);
        chk("step_top", rx, 8'h3E);
        wr(8'hA0, 8'h01);
        xf({ID_BYTE, 8'h20, 4'h1, 12'h000}, 20);
        rd(8'h90);
        chk("step_bottom", rx, 8'h01);
        summarize();
    end
endmodule
